//--- hdl/epg_gate.sv
// Power-up and command gate of a serial EEPROM.
// Assumes SPI pins come asynchronously from a host; the array itself lives elsewhere.
`timescale 1ns/10ps
// Operation
// R01: Supply rise enters standby, not undefined
// R02: Supply fall forces reset state
// R03: Write latch cleared on leaving reset
// R04: Host sends write enable before writes
// R05: No instruction until chip select low
// R06: Completed write clears write latch
// R07: Host raises select after exact count
// R08: Array access ignored while programming
// R09: Unknown opcode ignored, output stays tristated
// R10: Short write frame starts no programming
// R11: Enable/disable instructions drive latch, status
// R12: Ready bit one while programming
// R13: Only status read accepted while busy
// R14: Programming starts on select rising
module epg_gate #(
   parameter int unsigned PROG_CYC = epg_pkg::PROG_CYCLES // Internal write length
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_b,
   // Supply monitor
   input  wire logic              por_above,    // High while supply above trigger
   // SPI pins
   input  wire epg_pkg::epg_spi_s spi_in,
   output logic                   so_out,
   output logic                   so_oe_b,      // Low while driving
   // Status
   output epg_pkg::epg_stat_s     stat,
   output epg_pkg::epg_state_e    mode
);
   import epg_pkg::*;

   // ==========================================================
   // Synchronisers
   logic [2:0] s1_q;            // First stage, read only by s2
   logic [2:0] s2_q;            // Second stage
   logic       por1_q;
   logic       por2_q;
   logic       sck_d1_q;        // Previous clock level
   logic       cs_d1_q;         // Previous select level

   // Two flops per async pin; reset to idle pins (deselected, clock low) so no false edge follows reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s1_q   <= 3'h4;
         s2_q   <= 3'h4;
         por1_q <= 1'b0;
         por2_q <= 1'b0;
      end else begin
         s1_q   <= {spi_in.cs_b, spi_in.sck, spi_in.si};
         s2_q   <= s1_q;
         por1_q <= por_above;
         por2_q <= por1_q;
      end
   end

   // Edge history
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sck_d1_q <= 1'b0;
         cs_d1_q  <= 1'b1;
      end else begin
         sck_d1_q <= s2_q[1];
         cs_d1_q  <= s2_q[2];
      end
   end

   wire cs_b    = s2_q[2];
   wire si      = s2_q[0];
   wire sck_r   = s2_q[1] & ~sck_d1_q & ~cs_b;
   wire sck_f   = ~s2_q[1] & sck_d1_q & ~cs_b;
   wire cs_fall = cs_d1_q & ~cs_b;
   wire cs_rise = ~cs_d1_q & cs_b;

   // ==========================================================
   // Frame shifter
   logic [5:0] cnt_q;           // Bits in this selection; past 56 only byte phase moves
   logic [7:0] sh_q;            // Opcode shift
   logic [7:0] opc_q;           // Captured opcode
   logic       ignore_q;        // Selection discarded

   // Bit count and opcode capture
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         sh_q  <= '0;
         opc_q <= '0;
      end else if (cs_b) begin
         cnt_q <= '0;
      end else if (sck_r) begin
         sh_q <= {sh_q[6:0], si};
         // Long page writes must not freeze off a byte boundary
         if (cnt_q[5:3] == 3'h7)
            cnt_q <= {cnt_q[5:3], cnt_q[2:0] + 3'h1};
         else
            cnt_q <= cnt_q + 6'h01;
         if (cnt_q == OPC_DONE - 6'h01)
            opc_q <= {sh_q[6:0], si};
      end
   end

   wire opc_valid = (opc_q == OP_WRITE_ENABLE) || (opc_q == OP_WRITE_DISABLE) ||
                    (opc_q == OP_STATUS_READ)  || (opc_q == OP_STATUS_WRITE)  ||
                    (opc_q == OP_ARRAY_READ)   || (opc_q == OP_ARRAY_WRITE);
   wire opc_now   = sck_r && (cnt_q == OPC_DONE - 6'h01);
   wire have_opc  = (cnt_q >= OPC_DONE);

   // ==========================================================
   // Mode machine
   epg_state_e st_q;
   logic [31:0] prog_cnt_q;     // Remaining program cycles
   logic        wel_q;          // Write latch

   // Selection gate; busy drops everything except status read
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ignore_q <= 1'b0;
      end else if (cs_b) begin
         ignore_q <= 1'b0;
      end else if (have_opc && !ignore_q) begin
         if (!opc_valid)
            ignore_q <= 1'b1;                                    // [R09]
         else if (st_q == EPG_PROG && opc_q != OP_STATUS_READ)
            ignore_q <= 1'b1;                                    // [R08] [R13]
         else if (st_q != EPG_READY && st_q != EPG_PROG)
            ignore_q <= 1'b1;                                    // [R05]
      end
   end

   wire usable   = have_opc && !ignore_q && opc_valid && (st_q == EPG_READY);
   // Exact counts launch a write; a byte only partly shifted does not
   wire arr_ok   = (cnt_q >= WR_DATA_DONE) && ((cnt_q[2:0] & BYTE_MASK) == 3'h0); // [R10]
   wire sr_ok    = (cnt_q == SR_DATA_DONE);
   wire launch   = cs_rise && usable && wel_q &&
                   (((opc_q == OP_ARRAY_WRITE) && arr_ok) ||
                    ((opc_q == OP_STATUS_WRITE) && sr_ok)); // [R07] [R04]
   wire prog_end = (st_q == EPG_PROG) && (prog_cnt_q == 32'h1);

   // State moves
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= EPG_RESET;
      end else if (!por2_q) begin
         st_q <= EPG_RESET;                                      // [R02]
      end else begin
         case (st_q)
            EPG_RESET:   st_q <= EPG_STANDBY;                    // [R01]
            EPG_STANDBY: if (cs_fall) st_q <= EPG_READY;         // [R05]
            EPG_READY:   if (launch) st_q <= EPG_PROG;           // [R14]
            EPG_PROG:    if (prog_end) st_q <= EPG_READY;        // [R08]
            default:     st_q <= EPG_RESET;
         endcase
      end
   end

   // Program timer
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         prog_cnt_q <= '0;
      else if (launch && st_q == EPG_READY)
         prog_cnt_q <= PROG_CYC;
      else if (st_q == EPG_PROG && prog_cnt_q != 32'h0)
         prog_cnt_q <= prog_cnt_q - 32'h1;
   end

   // Write latch
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wel_q <= 1'b0;
      end else if (st_q == EPG_RESET || !por2_q) begin
         wel_q <= 1'b0;                                          // [R03]
      end else if (prog_end) begin
         wel_q <= 1'b0;                                          // [R06]
      end else if (cs_rise && usable && cnt_q == OPC_DONE) begin
         if (opc_q == OP_WRITE_ENABLE)
            wel_q <= 1'b1;                                       // [R11]
         else if (opc_q == OP_WRITE_DISABLE)
            wel_q <= 1'b0;                                       // [R11]
      end
   end

   // ==========================================================
   // Status read output
   logic [7:0] out_sh_q;
   logic       drive_q;

   // Shift status on falling clock; keep off for ignored selections
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         out_sh_q <= '0;
         drive_q  <= 1'b0;
      end else if (cs_b || !por2_q) begin
         // Supply loss mid-read releases the output at once
         drive_q  <= 1'b0;                                       // [R09]
      end else if (opc_now) begin
         out_sh_q <= {6'h00, wel_q, (st_q == EPG_PROG)};        // [R12]
         drive_q  <= ({sh_q[6:0], si} == OP_STATUS_READ) &&
                     (st_q == EPG_READY || st_q == EPG_PROG);    // [R09] [R13]
      end else if (sck_f && drive_q && cnt_q > OPC_DONE) begin
         out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
      end
   end

   // Registered outputs
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         so_out  <= 1'b0;
         so_oe_b <= 1'b1;
         stat    <= '0;
         mode    <= EPG_RESET;
      end else begin
         so_out               <= out_sh_q[7];
         so_oe_b              <= ~drive_q;
         stat.busy            <= (st_q == EPG_PROG);             // [R12]
         stat.write_latch_bit <= wel_q;
         stat.prog_start      <= launch && st_q == EPG_READY;
         stat.prog_done       <= prog_end;
         mode                 <= st_q;
      end
   end

   // ==========================================================
   // Checks
   property p_brownout;
      @(posedge clock) disable iff (!rst_b) !por2_q |=> st_q == EPG_RESET;
   endproperty
   a_brownout: assert property (p_brownout) else $error("no reset on supply loss"); // [R02]
   property p_standby;
      @(posedge clock) disable iff (!rst_b) st_q == EPG_RESET && por2_q |=> st_q == EPG_STANDBY;
   endproperty
   a_standby: assert property (p_standby) else $error("no standby after reset"); // [R01]
   property p_wel_clear;
      @(posedge clock) disable iff (!rst_b) st_q == EPG_STANDBY |-> !wel_q;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch set after reset"); // [R03]
   property p_done_clear;
      @(posedge clock) disable iff (!rst_b) prog_end |=> !wel_q && st_q != EPG_PROG;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("latch kept after write"); // [R06]
   property p_busy_bit;
      @(posedge clock) disable iff (!rst_b) st_q == EPG_PROG |=> stat.busy;
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("ready bit low while busy"); // [R12]
   property p_start_edge;
      @(posedge clock) disable iff (!rst_b) st_q == EPG_READY ##1 st_q == EPG_PROG |-> $past(cs_rise);
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("program without select rise"); // [R14]
   property p_quiet;
      @(posedge clock) disable iff (!rst_b) ignore_q |=> so_oe_b;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output driven on ignored frame"); // [R09]
   property p_short;
      @(posedge clock) disable iff (!rst_b) launch |-> cnt_q[2:0] == 3'h0;
   endproperty
   a_short: assert property (p_short) else $error("partial byte launched write"); // [R10]
   property p_wait_cs;
      @(posedge clock) disable iff (!rst_b) st_q == EPG_STANDBY |-> !launch;
   endproperty
   a_wait_cs: assert property (p_wait_cs) else $error("write before first select"); // [R05]
endmodule

//--- pkg/epg_pkg.sv
// Shared constants and carriers for the EEPROM power-up and command gate.
// Assumes a single system clock; SPI pins arrive asynchronously and are synchronised.
package epg_pkg;
   // ==========================================================
   // Opcodes seen on the serial input
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06; // write_enable_instruction
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04; // write_disable_instruction
   localparam logic [7:0] OP_STATUS_READ   = 8'h05; // status_read_instruction
   localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
   localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02;
   // ==========================================================
   // Frame geometry
   localparam int unsigned BYTE_BITS    = 8;
   localparam int unsigned ADDR_BITS    = 16;
   localparam logic [5:0]  OPC_DONE     = 6'h08; // Bits to complete opcode
   localparam logic [5:0]  SR_DATA_DONE = 6'h10; // Opcode plus one status byte
   localparam logic [5:0]  WR_DATA_DONE = 6'h20; // Opcode, address, first byte
   localparam logic [2:0]  BYTE_MASK    = 3'h7;
   // ==========================================================
   // Status bit positions
   localparam int unsigned ST_RDY = 0;
   localparam int unsigned ST_WEL = 1;
   // ==========================================================
   // Programming time
   localparam int unsigned PROG_TIME_NS = 5000;
   localparam int unsigned CLK_NS       = 10;
   localparam int unsigned PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      EPG_RESET   = 2'b00, // Supply below trigger
      EPG_STANDBY = 2'b01, // Powered, waiting for first select
      EPG_READY   = 2'b10, // Select seen, accepting instructions
      EPG_PROG    = 2'b11  // Internal write running
   } epg_state_e;
   typedef struct packed {
      logic cs_b;
      logic sck;
      logic si;
   } epg_spi_s;
   typedef struct packed {
      logic busy;
      logic write_latch_bit;
      logic prog_start;
      logic prog_done;
   } epg_stat_s;
endpackage

//--- verification/epg_host_model.sv
// Host SPI controller model that drives the gate's serial pins.
// Assumes one bench process calls send_frame; pins move on falling clock edges.
`timescale 1ns/10ps
module epg_host_model
   import epg_pkg::*;
(
   // Clock and device pins
   input  wire logic         clock,
   input  wire logic         so_out,
   input  wire logic         so_oe_b,
   output epg_pkg::epg_spi_s spi,
   // Readback of the answer byte
   output logic              rx_stb,
   output logic [7:0]        rx
);
   logic seen; // Device drove its output in this frame
   // ==========================================================
   // Idle pins: deselected, clock parked low
   initial begin
      spi    = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};
      rx_stb = 1'b0;
      rx     = 8'h00;
      seen   = 1'b0;
   end
   // ==========================================================
   // One frame, MSB first; clock high holds 4 cycles, low holds 8
   task automatic send_frame(input int n, input logic [39:0] d);
      seen = 1'b0;
      @(negedge clock);
      spi.cs_b = 1'b0; // Select before the first bit
      for (int i = 0; i < n; i++) begin
         repeat (4) @(negedge clock);
         spi.si = d[39-i];
         repeat (4) @(negedge clock);
         if (i >= 8) rx = {rx[6:0], so_out};
         seen = seen | ~so_oe_b;
         spi.sck = 1'b1;
         repeat (4) @(negedge clock);
         spi.sck = 1'b0;
      end
      repeat (4) @(negedge clock);
      spi.cs_b = 1'b1; // Raised after the count the bench chose
      spi.si   = ~spi.si; // Released line keeps no stale level
      @(negedge clock);
      rx_stb = seen;
      @(negedge clock);
      rx_stb = 1'b0;
      repeat (6) @(negedge clock);
   endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the EEPROM power-up and command gate.
// Assumes the host model drives the pins; results are matched from a note queue.
`timescale 1ns/10ps
module tb_top;
   import epg_pkg::*;
   localparam int unsigned PC = 1000; // Write runs twice the package's 500 cycles
   logic              clock, rst_b, por_above, so_out, so_oe_b, rx_stb;
   logic [7:0]        rx, op;
   epg_spi_s          spi;
   epg_stat_s         stat;
   epg_state_e        mode;
   logic [8:0]        notes[$]; // Expected results, oldest first
   int                miscompares = 0;
   int                cmp_count   = 0;
   int                seed        = 32'hbcaf;
   // ==========================================================
   // Device and host
   epg_gate #(.PROG_CYC(PC)) dut_u (.clock(clock), .rst_b(rst_b), .por_above(por_above),
      .spi_in(spi), .so_out(so_out), .so_oe_b(so_oe_b), .stat(stat), .mode(mode));
   epg_host_model host_u (.clock(clock), .so_out(so_out), .so_oe_b(so_oe_b),
      .spi(spi), .rx_stb(rx_stb), .rx(rx));
   // ==========================================================
   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Compare and count
   task automatic check(input logic [8:0] got, input logic [8:0] want);
      cmp_count++;
      if (got !== want) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // Latch, busy and mode together
   task automatic peek(input logic [3:0] want);
      check({5'h00, stat.write_latch_bit, stat.busy, mode}, {5'h00, want});
   endtask
   // Empty queue yields a value no result can match
   function automatic logic [8:0] pop();
      if (notes.size() == 0) return 9'h1ff;
      return notes.pop_front();
   endfunction
   task automatic test_done();
      check(9'(notes.size()), 9'h000);
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Watcher: every result must match the oldest note
   always @(posedge clock) begin
      #2; // Look once outputs have settled after the edge
      if (stat.prog_start === 1'b1) check(9'h100, pop());
      if (stat.prog_done === 1'b1) check(9'h101, pop());
      if (rx_stb === 1'b1) check({1'b0, rx}, pop());
   end
   // Bounded wait for the write to end
   task automatic wait_idle();
      for (int i = 0; i < 2 * PC && stat.busy !== 1'b0; i++) @(negedge clock);
   endtask
   task automatic power_up();
      por_above = 1'b1;
      repeat (6) @(negedge clock);
      peek({2'b00, EPG_STANDBY});
      // The first selection's own fall enters ready, so its opcode runs; keep the latch clear
      host_u.send_frame(8, {OP_WRITE_DISABLE, 32'h0});
      peek({2'b00, EPG_READY});
      $display("power-up done");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst_b     = 1'b0;
      por_above = 1'b0;
      repeat (4) @(negedge clock);
      peek({2'b00, EPG_RESET});
      check({8'h00, so_oe_b}, 9'h001);
      rst_b = 1'b1;
      repeat (6) @(negedge clock);
      peek({2'b00, EPG_RESET});
      power_up();
      host_u.send_frame(32, {OP_ARRAY_WRITE, 16'($random(seed)), 8'h5a, 8'h0});
      peek({2'b00, EPG_READY});
      host_u.send_frame(8, {OP_WRITE_ENABLE, 32'h0});
      peek({2'b10, EPG_READY});
      host_u.send_frame(8, {OP_WRITE_DISABLE, 32'h0});
      peek({2'b00, EPG_READY});
      host_u.send_frame(8, {OP_WRITE_ENABLE, 32'h0});
      host_u.send_frame(28, {OP_ARRAY_WRITE, 32'($random(seed))});
      peek({2'b10, EPG_READY});
      $display("latch tests done");
      notes.push_back(9'h100);
      host_u.send_frame(32, {OP_ARRAY_WRITE, 32'($random(seed))});
      peek({2'b11, EPG_PROG});
      notes.push_back(9'h003);
      host_u.send_frame(16, {OP_STATUS_READ, 32'h0});
      host_u.send_frame(8, {OP_WRITE_DISABLE, 32'h0});
      peek({2'b11, EPG_PROG});
      host_u.send_frame(32, {OP_ARRAY_WRITE, 32'($random(seed))});
      peek({2'b11, EPG_PROG});
      notes.push_back(9'h101);
      wait_idle();
      repeat (4) @(negedge clock);
      peek({2'b00, EPG_READY});
      $display("array write done");
      host_u.send_frame(8, {OP_WRITE_ENABLE, 32'h0});
      notes.push_back(9'h100);
      notes.push_back(9'h101);
      host_u.send_frame(16, {OP_STATUS_WRITE, 8'h00, 24'h0});
      wait_idle();
      repeat (4) @(negedge clock);
      peek({2'b00, EPG_READY});
      for (int k = 0; k < 4; k++) begin
         op = 8'($random(seed));
         if (op inside {[8'h01 : 8'h06]}) op = 8'hff;
         host_u.send_frame(16, {op, 8'($random(seed)), 24'h0});
         peek({2'b00, EPG_READY});
      end
      host_u.send_frame(8, {OP_ARRAY_READ, 32'h0});
      $display("opcode tests done");
      host_u.send_frame(8, {OP_WRITE_ENABLE, 32'h0});
      por_above = 1'b0;
      repeat (6) @(negedge clock);
      peek({2'b00, EPG_RESET});
      power_up();
      test_done();
   end
   // Watchdog
   initial begin
      #400000;
      miscompares++;
      test_done();
   end
endmodule
